// ---- shared/tew_pkg.sv ----
// shared constants and field layouts for the buffer entry write block
package tew_pkg;
    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int VPN_W = 19;
    localparam int TAG_W = 8;
    localparam int MASK_W = 16;
    localparam int PFN_W = 24;
    localparam int ATTR_W = 3;
    // ------------------------------------------------------------
    // entry-low field positions
    // ------------------------------------------------------------
    localparam int LO_G_POS = 0;
    localparam int LO_V_POS = 1;
    localparam int LO_D_POS = 2;
    localparam int LO_C_POS = 3;
    localparam int LO_PFN_POS = 6;
    localparam int LO_W = 32;
    // ------------------------------------------------------------
    // entry-high and page mask field positions
    // ------------------------------------------------------------
    localparam int HI_TAG_POS = 0;
    localparam int HI_VPN_POS = 13;
    localparam int HI_W = 32;
    localparam int PM_MASK_POS = 13;
    // ------------------------------------------------------------
    // entry layout and defaults
    // ------------------------------------------------------------
    localparam int ENTRY_W = VPN_W + TAG_W + MASK_W + 1 + 2 * (PFN_W + ATTR_W + 2);
    localparam int DEF_ENTRIES = 16;
    localparam int DEF_RELEASE = 2;
    localparam logic [ENTRY_W-1:0] ENTRY_RST = '0;
endpackage : tew_pkg

// ---- logic/tew_entry_pack.sv ----
// packs staging registers into one buffer entry word
module tew_entry_pack #(
    parameter bit ZERO_MASKED = 1'b1
) (
    input wire logic [tew_pkg::HI_W-1:0] entryHigh,
    input wire logic [tew_pkg::LO_W-1:0] evenLow,
    input wire logic [tew_pkg::LO_W-1:0] oddLow,
    input wire logic [tew_pkg::HI_W-1:0] page_size_mask_reg,
    output logic [tew_pkg::ENTRY_W-1:0] entryWord
);
    logic [tew_pkg::MASK_W-1:0] mask;
    logic [tew_pkg::VPN_W-1:0] vpnMask;
    logic [tew_pkg::PFN_W-1:0] pfnMask;
    logic [tew_pkg::VPN_W-1:0] vpn;
    logic [tew_pkg::PFN_W-1:0] pfnEven;
    logic [tew_pkg::PFN_W-1:0] pfnOdd;
    logic glob;

    always_comb begin
        mask = page_size_mask_reg[tew_pkg::PM_MASK_POS +: tew_pkg::MASK_W];
        // lsb-aligned masks; zero when zeroing is not chosen
        vpnMask = ZERO_MASKED ? tew_pkg::VPN_W'(mask) : '0;
        pfnMask = ZERO_MASKED ? tew_pkg::PFN_W'(mask) : '0;
        vpn = entryHigh[tew_pkg::HI_VPN_POS +: tew_pkg::VPN_W] & ~vpnMask;
        pfnEven = evenLow[tew_pkg::LO_PFN_POS +: tew_pkg::PFN_W] & ~pfnMask;
        pfnOdd = oddLow[tew_pkg::LO_PFN_POS +: tew_pkg::PFN_W] & ~pfnMask;
        glob = evenLow[tew_pkg::LO_G_POS] & oddLow[tew_pkg::LO_G_POS];
        entryWord = {vpn, entryHigh[tew_pkg::HI_TAG_POS +: tew_pkg::TAG_W], mask, glob,
            pfnEven, evenLow[tew_pkg::LO_C_POS +: tew_pkg::ATTR_W],
            evenLow[tew_pkg::LO_D_POS], evenLow[tew_pkg::LO_V_POS],
            pfnOdd, oddLow[tew_pkg::LO_C_POS +: tew_pkg::ATTR_W],
            oddLow[tew_pkg::LO_D_POS], oddLow[tew_pkg::LO_V_POS]};
    end
endmodule : tew_entry_pack

// ---- logic/tew_entry_write.sv ----
// buffer entry write engine: indexed and replacement-slot writes
module tew_entry_write #(
    parameter int ENTRIES = tew_pkg::DEF_ENTRIES,
    parameter bit ZERO_MASKED = 1'b1,
    parameter bit DETECT_MULTI = 1'b1,
    parameter int IDX_W = $clog2(tew_pkg::DEF_ENTRIES)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic writeSelectedSlotOp,
    input wire logic writeReplacementSlotOp,
    input wire logic privEnable,
    input wire logic [IDX_W-1:0] entrySelector,
    input wire logic [IDX_W-1:0] replacementPointer,
    input wire logic [tew_pkg::HI_W-1:0] entryHighStagingReg,
    input wire logic [tew_pkg::LO_W-1:0] evenEntryLowReg,
    input wire logic [tew_pkg::LO_W-1:0] oddEntryLowReg,
    input wire logic [tew_pkg::HI_W-1:0] pageSizeMaskReg,
    input wire logic [IDX_W-1:0] readIndex,
    output logic [tew_pkg::ENTRY_W-1:0] readEntry,
    output logic writeDone,
    output logic [IDX_W-1:0] writeSlot,
    output logic machineCheck,
    output logic coprocUnusable
);
    // ------------------------------------------------------------
    // entry fields
    // ------------------------------------------------------------
    localparam int LO_FIELDS = tew_pkg::PFN_W + tew_pkg::ATTR_W + 2;
    localparam int MASK_LSB = 2 * LO_FIELDS + 1;
    localparam int TAG_LSB = MASK_LSB + tew_pkg::MASK_W;
    localparam int VPN_LSB = TAG_LSB + tew_pkg::TAG_W;
    localparam int GLB_POS = 2 * LO_FIELDS;
    localparam int PFN_ODD_LSB = tew_pkg::ATTR_W + 2;
    localparam int PFN_EVEN_LSB = LO_FIELDS + PFN_ODD_LSB;

    logic [tew_pkg::ENTRY_W-1:0] table_reg [ENTRIES];
    logic [tew_pkg::ENTRY_W-1:0] newEntry;
    logic [ENTRIES-1:0] valid_reg;
    logic [ENTRIES-1:0] valid_next;
    logic [ENTRIES-1:0] hitVec;

    // a stale copy matching the new entry is the multi-hit hazard
    function automatic logic entry_match(input logic [tew_pkg::ENTRY_W-1:0] a,
                                         input logic [tew_pkg::ENTRY_W-1:0] b);
        logic [tew_pkg::VPN_W-1:0] m;
        logic tagOk;
        m = tew_pkg::VPN_W'(a[MASK_LSB +: tew_pkg::MASK_W] | b[MASK_LSB +: tew_pkg::MASK_W]);
        tagOk = a[GLB_POS] | b[GLB_POS] | (a[TAG_LSB +: tew_pkg::TAG_W] == b[TAG_LSB +: tew_pkg::TAG_W]);
        entry_match = ((a[VPN_LSB +: tew_pkg::VPN_W] & ~m) == (b[VPN_LSB +: tew_pkg::VPN_W] & ~m)) & tagOk;
    endfunction : entry_match

    tew_entry_pack #(
        .ZERO_MASKED(ZERO_MASKED)
    ) u_pack (
        .entryHigh(entryHighStagingReg),
        .evenLow(evenEntryLowReg),
        .oddLow(oddEntryLowReg),
        .page_size_mask_reg(pageSizeMaskReg),
        .entryWord(newEntry)
    );

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TEW_OP_IDX = 2'b01,
        TEW_OP_RND = 2'b10
    } tew_op_t;

    logic anyOp;
    logic doWrite;
    tew_op_t opKind;
    logic [IDX_W-1:0] slot;
    logic multiHit;
    logic writeDone_next;
    logic [IDX_W-1:0] writeSlot_next;
    logic machineCheck_next;
    logic coprocUnusable_next;
    logic [tew_pkg::ENTRY_W-1:0] readEntry_next;

    always_comb begin
        anyOp = writeSelectedSlotOp | writeReplacementSlotOp;
        doWrite = anyOp & privEnable;
        // indexed wins if both are raised together
        opKind = writeSelectedSlotOp ? TEW_OP_IDX : TEW_OP_RND;
        slot = (opKind == TEW_OP_IDX) ? entrySelector : replacementPointer;
        // out-of-range selector is software's fault; write is dropped here
        if (32'(slot) >= ENTRIES) begin
            doWrite = 1'b0;
        end
        for (int i = 0; i < ENTRIES; i++) begin
            hitVec[i] = valid_reg[i] && (i != 32'(slot)) && entry_match(table_reg[i], newEntry);
        end
        // only the write path checks, so probes and reads never flag it
        multiHit = DETECT_MULTI && doWrite && (|hitVec);
        valid_next = valid_reg;
        if (doWrite) begin
            valid_next[slot] = 1'b1;
        end
        // the entry is still written on a multi-match; the trap tells software to clean up
        writeDone_next = doWrite;
        // slot holds between writes so the last target stays visible
        writeSlot_next = doWrite ? slot : writeSlot;
        machineCheck_next = multiHit;
        coprocUnusable_next = anyOp & ~privEnable;
        // registered read port keeps the table mux off the output path, at one cycle of latency
        readEntry_next = table_reg[readIndex];
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            valid_reg <= '0;
            writeDone <= 1'b0;
            writeSlot <= '0;
            machineCheck <= 1'b0;
            coprocUnusable <= 1'b0;
            readEntry <= tew_pkg::ENTRY_RST;
        end else begin
            valid_reg <= valid_next;
            writeDone <= writeDone_next;
            writeSlot <= writeSlot_next;
            machineCheck <= machineCheck_next;
            coprocUnusable <= coprocUnusable_next;
            readEntry <= readEntry_next;
        end
    end

    // whole entry in one store so lookups never see a torn entry
    always_ff @(posedge clk) begin
        if (doWrite) begin
            table_reg[slot] <= newEntry;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_no_priv_write: assert property (@(posedge clk) disable iff (srst)
        anyOp && !privEnable |=> coprocUnusable && !writeDone)
        else $error("write done without privilege");
    a_idx_slot: assert property (@(posedge clk) disable iff (srst)
        writeSelectedSlotOp && privEnable && 32'(entrySelector) < ENTRIES |=> writeDone && writeSlot == $past(entrySelector))
        else $error("indexed write wrong slot");
    a_rnd_slot: assert property (@(posedge clk) disable iff (srst)
        !writeSelectedSlotOp && writeReplacementSlotOp && privEnable && 32'(replacementPointer) < ENTRIES
        |=> writeDone && writeSlot == $past(replacementPointer))
        else $error("random write wrong slot");
    a_mc_only_write: assert property (@(posedge clk) disable iff (srst)
        machineCheck |-> writeDone)
        else $error("machine check without write");
    a_mc_on_hit: assert property (@(posedge clk) disable iff (srst)
        DETECT_MULTI && doWrite && (|hitVec) |=> machineCheck)
        else $error("multi match not flagged");
    a_glob_and: assert property (@(posedge clk) disable iff (srst)
        newEntry[GLB_POS] == (evenEntryLowReg[tew_pkg::LO_G_POS] & oddEntryLowReg[tew_pkg::LO_G_POS]))
        else $error("shared bit not anded");
    a_vpn_zero: assert property (@(posedge clk) disable iff (srst)
        ZERO_MASKED |-> (newEntry[VPN_LSB +: tew_pkg::VPN_W]
            & tew_pkg::VPN_W'(pageSizeMaskReg[tew_pkg::PM_MASK_POS +: tew_pkg::MASK_W])) == '0)
        else $error("masked page bits kept");
    a_store_entry: assert property (@(posedge clk) disable iff (srst)
        doWrite |=> table_reg[writeSlot] == $past(newEntry))
        else $error("entry not stored whole");
    a_mask_copy: assert property (@(posedge clk) disable iff (srst)
        newEntry[MASK_LSB +: tew_pkg::MASK_W] == pageSizeMaskReg[tew_pkg::PM_MASK_POS +: tew_pkg::MASK_W])
        else $error("mask not copied");
    // packing checks run every cycle, not only on writes, so a bad field map shows early
    a_tag_copy: assert property (@(posedge clk) disable iff (srst)
        newEntry[TAG_LSB +: tew_pkg::TAG_W] == entryHighStagingReg[tew_pkg::HI_TAG_POS +: tew_pkg::TAG_W])
        else $error("tag not copied");
    a_even_attr: assert property (@(posedge clk) disable iff (srst)
        newEntry[LO_FIELDS +: tew_pkg::ATTR_W + 2] == evenEntryLowReg[tew_pkg::LO_V_POS +: tew_pkg::ATTR_W + 2])
        else $error("even attributes not copied");
    a_odd_attr: assert property (@(posedge clk) disable iff (srst)
        newEntry[0 +: tew_pkg::ATTR_W + 2] == oddEntryLowReg[tew_pkg::LO_V_POS +: tew_pkg::ATTR_W + 2])
        else $error("odd attributes not copied");
    a_pfn_zero: assert property (@(posedge clk) disable iff (srst)
        ZERO_MASKED |-> ((newEntry[PFN_EVEN_LSB +: tew_pkg::PFN_W] | newEntry[PFN_ODD_LSB +: tew_pkg::PFN_W])
            & tew_pkg::PFN_W'(pageSizeMaskReg[tew_pkg::PM_MASK_POS +: tew_pkg::MASK_W])) == '0)
        else $error("masked frame bits kept");
    // keep mode only: masked bits must pass through untouched
    a_vpn_keep: assert property (@(posedge clk) disable iff (srst)
        !ZERO_MASKED |-> newEntry[VPN_LSB +: tew_pkg::VPN_W]
            == entryHighStagingReg[tew_pkg::HI_VPN_POS +: tew_pkg::VPN_W])
        else $error("page bits zeroed while kept");
    a_pfn_keep: assert property (@(posedge clk) disable iff (srst)
        !ZERO_MASKED |-> newEntry[PFN_EVEN_LSB +: tew_pkg::PFN_W] == evenEntryLowReg[tew_pkg::LO_PFN_POS +: tew_pkg::PFN_W]
            && newEntry[PFN_ODD_LSB +: tew_pkg::PFN_W] == oddEntryLowReg[tew_pkg::LO_PFN_POS +: tew_pkg::PFN_W])
        else $error("frame bits zeroed while kept");
    a_priv_no_store: assert property (@(posedge clk) disable iff (srst)
        anyOp && !privEnable |=> valid_reg == $past(valid_reg))
        else $error("refused write marked a slot");
    a_slot_valid: assert property (@(posedge clk) disable iff (srst)
        doWrite |=> valid_reg[writeSlot])
        else $error("written slot not valid");
    a_cu_excl: assert property (@(posedge clk) disable iff (srst)
        coprocUnusable |-> !writeDone && !machineCheck)
        else $error("refused write reported as done");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    c_idx_write: cover property (@(posedge clk) writeSelectedSlotOp && doWrite);
    c_rnd_write: cover property (@(posedge clk) !writeSelectedSlotOp && writeReplacementSlotOp && doWrite);
    c_mc: cover property (@(posedge clk) machineCheck);
    c_cpu: cover property (@(posedge clk) coprocUnusable);
    c_masked_write: cover property (@(posedge clk) doWrite && (|pageSizeMaskReg[tew_pkg::PM_MASK_POS +: tew_pkg::MASK_W]));
endmodule : tew_entry_write

// ---- tb/tew_pipe_model.sv ----
// pipeline model that issues entry write operations to the write block
module tew_pipe_model #(
    parameter int IDX_W = 4
) (
    input wire logic clk,
    output logic writeSelectedSlotOp,
    output logic writeReplacementSlotOp,
    output logic privEnable,
    output logic [IDX_W-1:0] entrySelector,
    output logic [IDX_W-1:0] replacementPointer,
    output logic [tew_pkg::HI_W-1:0] entryHighStagingReg,
    output logic [tew_pkg::LO_W-1:0] evenEntryLowReg,
    output logic [tew_pkg::LO_W-1:0] oddEntryLowReg,
    output logic [tew_pkg::HI_W-1:0] pageSizeMaskReg
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {writeSelectedSlotOp, writeReplacementSlotOp, privEnable} = 3'h0;
        {entrySelector, replacementPointer} = '0;
        {entryHighStagingReg, evenEntryLowReg, oddEntryLowReg, pageSizeMaskReg} = '0;
    end
    // the unused slot source gets the inverse slot, so a wrong source choice shows
    task automatic issue(input bit rnd, input logic [IDX_W-1:0] slot, input logic [31:0] hi, l0, l1, pm,
                         input logic pv);
        @(negedge clk);
        writeSelectedSlotOp = !rnd;
        writeReplacementSlotOp = rnd;
        entrySelector = rnd ? ~slot : slot;
        replacementPointer = rnd ? slot : ~slot;
        {entryHighStagingReg, evenEntryLowReg, oddEntryLowReg, pageSizeMaskReg} = {hi, l0, l1, pm};
        privEnable = pv;
        @(negedge clk);
        {writeSelectedSlotOp, writeReplacementSlotOp} = 2'h0;
    endtask : issue
endmodule : tew_pipe_model

// ---- tb/tew_entry_write_tb_top.sv ----
// self-checking bench for the buffer entry write block
module tew_entry_write_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EW = tew_pkg::ENTRY_W;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wSel, wRep, priv, writeDone, machineCheck, coprocUnusable;
    logic [3:0] sel, rep, writeSlot;
    logic [3:0] readIndex = 4'h0;
    logic [31:0] hi, l0, l1, pm;
    logic [EW-1:0] readEntry;
    logic [EW-1:0] keepEntry;
    logic [EW-1:0] shadow [16];
    int mismatches = 0;
    int nTests = 0;
    always #12.5 clk = ~clk;
    tew_pipe_model #(.IDX_W(4)) i_pipe (.clk(clk), .writeSelectedSlotOp(wSel), .writeReplacementSlotOp(wRep),
        .privEnable(priv), .entrySelector(sel), .replacementPointer(rep), .entryHighStagingReg(hi),
        .evenEntryLowReg(l0), .oddEntryLowReg(l1), .pageSizeMaskReg(pm));
    tew_entry_write #(.ENTRIES(16), .IDX_W(4)) i_dut (.clk(clk), .srst(srst), .writeSelectedSlotOp(wSel),
        .writeReplacementSlotOp(wRep), .privEnable(priv), .entrySelector(sel), .replacementPointer(rep),
        .entryHighStagingReg(hi), .evenEntryLowReg(l0), .oddEntryLowReg(l1), .pageSizeMaskReg(pm),
        .readIndex(readIndex), .readEntry(readEntry), .writeDone(writeDone), .writeSlot(writeSlot),
        .machineCheck(machineCheck), .coprocUnusable(coprocUnusable));
    // second copy keeps masked bits, so the other zeroing choice is exercised too
    tew_entry_write #(.ENTRIES(16), .ZERO_MASKED(1'b0), .IDX_W(4)) i_keep (.clk(clk), .srst(srst),
        .writeSelectedSlotOp(wSel), .writeReplacementSlotOp(wRep), .privEnable(priv), .entrySelector(sel),
        .replacementPointer(rep), .entryHighStagingReg(hi), .evenEntryLowReg(l0), .oddEntryLowReg(l1),
        .pageSizeMaskReg(pm), .readIndex(readIndex), .readEntry(keepEntry), .writeDone(), .writeSlot(),
        .machineCheck(), .coprocUnusable());
    // -----------------------------------------------------------
    // checking helpers
    // -----------------------------------------------------------
    task automatic chk(input logic [EW-1:0] got, input logic [EW-1:0] exp);
        nTests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // mask bits clear the low bits of page and frame numbers, lsb aligned
    function automatic logic [EW-1:0] ent(input logic [31:0] h, a, b, p, input bit z);
        logic [15:0] m;
        logic [15:0] k;
        m = p[28:13];
        k = z ? m : 16'h0;
        return {h[31:13] & ~{3'h0, k}, h[7:0], m, a[0] & b[0], a[29:6] & ~{8'h0, k}, a[5:3], a[2], a[1],
                b[29:6] & ~{8'h0, k}, b[5:3], b[2], b[1]};
    endfunction : ent
    // one write, its one-cycle answer, then a read back of the slot
    task automatic wr(input bit rnd, input logic [3:0] s, input logic [31:0] h, a, b, p, input logic pv,
                      input logic mc);
        i_pipe.issue(rnd, s, h, a, b, p, pv);
        chk(writeDone, pv);
        chk(coprocUnusable, !pv);
        chk(machineCheck, mc);
        if (pv) chk(writeSlot, s);
        if (pv) shadow[s] = ent(h, a, b, p, 1'b1);
        readIndex = s;
        @(negedge clk);
        chk(readEntry, shadow[s]);
    endtask : wr
    task automatic stop_test();
        if (mismatches == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk({writeDone, machineCheck, coprocUnusable, writeSlot}, '0);
        wr(1'b0, 4'h3, 32'h1234_a05a, 32'h0abc_de2f, 32'h1357_9bdd, 32'h0, 1'b1, 1'b0);
        wr(1'b1, 4'hf, 32'hfedc_b0a5, 32'h3fff_ffc7, 32'h2aaa_aaaa, 32'h1fff_e000, 1'b1, 1'b0);
        chk(readEntry, ent(32'hfedc_b0a5, 32'h3fff_ffc7, 32'h2aaa_aaaa, 32'h1fff_e000, 1'b1));
        // same page pair and tag as slot 3, so the new entry collides with it
        wr(1'b0, 4'h5, 32'h1234_a05a, 32'h0111_1112, 32'h0222_2224, 32'h0, 1'b1, 1'b1);
        // refused write must leave slot 3 untouched
        wr(1'b1, 4'h3, 32'h0f0f_0f0f, 32'h1, 32'h1, 32'h0, 1'b0, 1'b0);
        wr(1'b0, 4'h0, 32'h8001_e001, 32'h3fff_ffff, 32'h3fff_ffff, 32'h0001_e000, 1'b1, 1'b0);
        chk(keepEntry, ent(32'h8001_e001, 32'h3fff_ffff, 32'h3fff_ffff, 32'h0001_e000, 1'b0));
        // reset drops every valid bit, so the old slot 3 copy no longer collides
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk({writeDone, machineCheck, coprocUnusable, writeSlot}, '0);
        wr(1'b1, 4'h5, 32'h1234_a05a, 32'h0111_1112, 32'h0222_2224, 32'h0, 1'b1, 1'b0);
        stop_test();
    end
endmodule : tew_entry_write_tb_top
